//--- src/dcsm_pkg.sv
// Package for the drive-control state machine: control/status word layout,
// state codes and setting encodings. Shared by the design and its checks.
package dcsm_pkg;
  localparam int CW_W = 16;
  // Control word bit positions
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_EN_VOLT   = 1;
  localparam int CW_QSTOP_N   = 2;
  localparam int CW_EN_OP     = 3;
  localparam int CW_FLT_RST   = 7;
  localparam int CW_HALT      = 8;
  // Status word bit positions
  localparam int SW_READY   = 0;
  localparam int SW_SWON    = 1;
  localparam int SW_OPEN    = 2;
  localparam int SW_FAULT   = 3;
  localparam int SW_VOLT    = 4;
  localparam int SW_QSTOP   = 5;
  localparam int SW_SODIS   = 6;
  localparam int SW_WARN    = 7;
  localparam int SW_REMOTE  = 9;
  localparam int SW_TARGET  = 10;
  localparam int SW_LIMIT   = 11;
  localparam int SW_OPM12   = 12;
  localparam int SW_OPM13   = 13;
  localparam int SW_WARN2   = 15;
  // Control source value that selects state-machine control
  localparam logic [5:0] SRC_STATE_MACHINE = 6'h01;
  // Transition 5 behaviour settings
  localparam logic [1:0] T5_COAST = 2'h0;
  localparam logic [1:0] T5_DCBRAKE = 2'h1;
  localparam logic [1:0] T5_RAMP = 2'h2;
  // Operating states
  typedef enum logic [2:0] {
    DCSM_SODIS   = 3'b000,
    DCSM_READY   = 3'b001,
    DCSM_SWON    = 3'b010,
    DCSM_OPEN    = 3'b011,
    DCSM_QSTOP   = 3'b100,
    DCSM_FLTREAC = 3'b101,
    DCSM_FAULT   = 3'b110,
    DCSM_T5STOP  = 3'b111
  } dcsm_state_t;
endpackage

//--- src/dcsm_drive_control.sv
// Drive-control state machine: decodes the control word into state changes,
// gated by release inputs and mains presence; builds the status word.
// Assumes the drive core supplies stop/brake completion and flag levels.
`timescale 1ns/1ps
module dcsm_drive_control (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [15:0] driveCommandWord,
  input  wire logic [5:0]  controlSource,
  input  wire logic        motionControl,
  input  wire logic [1:0]  transition5Mode,
  input  wire logic        safeReleaseA,
  input  wire logic        safeReleaseB,
  input  wire logic        digitalInputOne,
  input  wire logic        startClockwiseInput,
  input  wire logic        startAnticlockwiseInput,
  input  wire logic        mainsPresent,
  input  wire logic        faultDetected,
  input  wire logic        faultReactionDone,
  input  wire logic        stopDone,
  input  wire logic        holdTimeExpired,
  input  wire logic        brakeDone,
  input  wire logic        internalWarning,
  input  wire logic        targetInHysteresis,
  input  wire logic        powerFailAtZero,
  input  wire logic        limitActive,
  input  wire logic        preFaultWarning,
  input  wire logic [1:0]  opModeStatus,
  output logic [15:0]      driveStatusWord,
  output logic             inverterEnable,
  output logic             rampStopActive,
  output logic             emergencyRampActive,
  output logic             dcBrakeActive,
  output logic [3:0]       motionCmdBits
);

  dcsm_pkg::dcsm_state_t stateReg;
  dcsm_pkg::dcsm_state_t stateNext;
  logic faultRstPrevReg;
  logic faultRstPulse;
  logic [1:0] t5ModeReg;
  logic [15:0] statusNext;
  logic srcSel;
  logic hwRelease;
  logic op4Allowed;
  logic cmdShutdown;
  logic cmdSwitchOn;
  logic cmdEnableOp;
  logic cmdDisableOp;
  logic cmdDisableVolt;
  logic cmdQuickStop;

  // Bit pattern match on the low four bits; upper bits 9-15 never looked at
  function automatic logic cwMatch(input logic [3:0] cw, input logic [3:0] val,
                                   input logic [3:0] care);
    cwMatch = ((cw ^ val) & care) == 4'h0;
  endfunction

  assign srcSel = (controlSource == dcsm_pkg::SRC_STATE_MACHINE);
  // Motion control needs only the first input; else a start direction in its place
  assign hwRelease = safeReleaseA && safeReleaseB &&
                     (motionControl ? digitalInputOne
                      : (startClockwiseInput || startAnticlockwiseInput));
  assign op4Allowed = motionControl ? (safeReleaseA && safeReleaseB)
                      : (hwRelease && mainsPresent);

  // Command decode: disable voltage outranks quick stop outranks the rest
  assign cmdDisableVolt = !driveCommandWord[dcsm_pkg::CW_EN_VOLT];
  assign cmdQuickStop = cwMatch(driveCommandWord[3:0], 4'h2, 4'h6);
  assign cmdShutdown = cwMatch(driveCommandWord[3:0], 4'h6, 4'h7);
  assign cmdSwitchOn = cwMatch(driveCommandWord[3:0], 4'h7, 4'h7);
  assign cmdEnableOp = cwMatch(driveCommandWord[3:0], 4'hF, 4'hF);
  assign cmdDisableOp = cwMatch(driveCommandWord[3:0], 4'h7, 4'hF);
  assign faultRstPulse = driveCommandWord[dcsm_pkg::CW_FLT_RST] && !faultRstPrevReg;

  // Edge detector on the fault-reset bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      faultRstPrevReg <= 1'b0;
    end else begin
      faultRstPrevReg <= driveCommandWord[dcsm_pkg::CW_FLT_RST];
    end
  end

  // Transition 5 mode latched on entry steers the stop's exit; the ramp and DC-brake outputs follow the live transition5Mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      t5ModeReg <= dcsm_pkg::T5_COAST;
    end else if (stateReg == dcsm_pkg::DCSM_OPEN) begin
      t5ModeReg <= transition5Mode;
    end
  end

  // Next-state logic; anything not matched keeps the state
  always_comb begin
    stateNext = stateReg;
    if (faultDetected && stateReg != dcsm_pkg::DCSM_FAULT &&
        stateReg != dcsm_pkg::DCSM_FLTREAC) begin
      stateNext = dcsm_pkg::DCSM_FLTREAC;
    end else if (srcSel || stateReg == dcsm_pkg::DCSM_FLTREAC) begin
      case (stateReg)
        dcsm_pkg::DCSM_SODIS: begin
          if (cmdShutdown) stateNext = dcsm_pkg::DCSM_READY;
        end
        dcsm_pkg::DCSM_READY: begin
          if (cmdDisableVolt || cmdQuickStop) begin
            stateNext = dcsm_pkg::DCSM_SODIS;
          end else if (cmdEnableOp && !motionControl && op4Allowed) begin
            stateNext = dcsm_pkg::DCSM_OPEN;
          end else if (cmdSwitchOn && mainsPresent) begin
            stateNext = dcsm_pkg::DCSM_SWON;
          end
        end
        dcsm_pkg::DCSM_SWON: begin
          if (cmdDisableVolt || cmdQuickStop) begin
            stateNext = dcsm_pkg::DCSM_SODIS;
          end else if (cmdShutdown) begin
            stateNext = dcsm_pkg::DCSM_READY;
          end else if (cmdEnableOp && op4Allowed) begin
            stateNext = dcsm_pkg::DCSM_OPEN;
          end
        end
        dcsm_pkg::DCSM_OPEN: begin
          if (cmdDisableVolt) begin
            stateNext = dcsm_pkg::DCSM_SODIS;
          end else if (cmdQuickStop) begin
            stateNext = dcsm_pkg::DCSM_QSTOP;
          end else if (cmdShutdown) begin
            stateNext = dcsm_pkg::DCSM_READY;
          end else if (cmdDisableOp) begin
            if (motionControl || transition5Mode == dcsm_pkg::T5_COAST) begin
              stateNext = dcsm_pkg::DCSM_SWON;
            end else begin
              stateNext = dcsm_pkg::DCSM_T5STOP;
            end
          end
        end
        dcsm_pkg::DCSM_T5STOP: begin
          // DC brake locks out new commands; ramp may be re-enabled
          if (t5ModeReg == dcsm_pkg::T5_DCBRAKE) begin
            if (brakeDone) stateNext = dcsm_pkg::DCSM_SWON;
          end else if (cmdDisableVolt) begin
            stateNext = dcsm_pkg::DCSM_SODIS;
          end else if (cmdEnableOp && op4Allowed) begin
            stateNext = dcsm_pkg::DCSM_OPEN;
          end else if (stopDone && holdTimeExpired) begin
            stateNext = dcsm_pkg::DCSM_SWON;
          end
        end
        dcsm_pkg::DCSM_QSTOP: begin
          if (cmdDisableVolt) begin
            stateNext = dcsm_pkg::DCSM_SODIS;
          end else if (motionControl || (stopDone && holdTimeExpired)) begin
            stateNext = dcsm_pkg::DCSM_SODIS;
          end
        end
        dcsm_pkg::DCSM_FLTREAC: begin
          if (faultReactionDone) stateNext = dcsm_pkg::DCSM_FAULT;
        end
        dcsm_pkg::DCSM_FAULT: begin
          if (faultRstPulse) stateNext = dcsm_pkg::DCSM_SODIS;
        end
        default: stateNext = dcsm_pkg::DCSM_SODIS;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= dcsm_pkg::DCSM_SODIS;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Status word assembled from the next state so it lines up with stateReg
  always_comb begin
    statusNext = 16'h0000;
    case (stateNext)
      dcsm_pkg::DCSM_SODIS:   statusNext[6:0] = 7'h40;
      dcsm_pkg::DCSM_READY:   statusNext[6:0] = 7'h21;
      dcsm_pkg::DCSM_SWON:    statusNext[6:0] = 7'h23;
      dcsm_pkg::DCSM_OPEN:    statusNext[6:0] = 7'h27;
      dcsm_pkg::DCSM_T5STOP:  statusNext[6:0] = 7'h27;
      dcsm_pkg::DCSM_QSTOP:   statusNext[6:0] = 7'h07;
      dcsm_pkg::DCSM_FLTREAC: statusNext[6:0] = 7'h0F;
      dcsm_pkg::DCSM_FAULT:   statusNext[6:0] = 7'h08;
      default:                statusNext[6:0] = 7'h40;
    endcase
    statusNext[dcsm_pkg::SW_VOLT] = mainsPresent;
    statusNext[dcsm_pkg::SW_WARN] = internalWarning;
    statusNext[dcsm_pkg::SW_REMOTE] = srcSel && hwRelease;
    statusNext[dcsm_pkg::SW_TARGET] = targetInHysteresis || powerFailAtZero;
    statusNext[dcsm_pkg::SW_LIMIT] = limitActive;
    statusNext[dcsm_pkg::SW_OPM12] = motionControl && opModeStatus[0];
    statusNext[dcsm_pkg::SW_OPM13] = motionControl && opModeStatus[1];
    statusNext[dcsm_pkg::SW_WARN2] = preFaultWarning;
  end

  // Registered outputs toward host and drive core
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      driveStatusWord     <= 16'h0040;
      inverterEnable      <= 1'b0;
      rampStopActive      <= 1'b0;
      emergencyRampActive <= 1'b0;
      dcBrakeActive       <= 1'b0;
      motionCmdBits       <= 4'h0;
    end else begin
      driveStatusWord     <= statusNext;
      inverterEnable      <= (stateNext == dcsm_pkg::DCSM_OPEN) ||
                             (stateNext == dcsm_pkg::DCSM_T5STOP) ||
                             (stateNext == dcsm_pkg::DCSM_QSTOP);
      rampStopActive      <= (stateNext == dcsm_pkg::DCSM_T5STOP) &&
                             (transition5Mode == dcsm_pkg::T5_RAMP);
      emergencyRampActive <= (stateNext == dcsm_pkg::DCSM_QSTOP) && !motionControl;
      dcBrakeActive       <= (stateNext == dcsm_pkg::DCSM_T5STOP &&
                              transition5Mode == dcsm_pkg::T5_DCBRAKE) ||
                             (stateNext == dcsm_pkg::DCSM_QSTOP && stopDone &&
                              !holdTimeExpired && !motionControl);
      motionCmdBits       <= motionControl ? {driveCommandWord[dcsm_pkg::CW_HALT],
                                              driveCommandWord[6:4]} : 4'h0;
    end
  end

  // Checks
  remote_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    driveStatusWord[dcsm_pkg::SW_REMOTE] |-> $past(srcSel && hwRelease))
    else $error("remote bit without source and release");
  no_swon_nomains_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (stateReg == dcsm_pkg::DCSM_READY && !mainsPresent && !faultDetected)
    |=> stateReg != dcsm_pkg::DCSM_SWON)
    else $error("switched on without mains");
  op_release_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ($changed(stateReg) && stateReg == dcsm_pkg::DCSM_OPEN) |-> $past(op4Allowed))
    else $error("enable without release");
  src_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!srcSel && !faultDetected && stateReg != dcsm_pkg::DCSM_FLTREAC) |=> $stable(stateReg))
    else $error("state moved without state-machine source");
  // Guarded by the previous reset level: the first edge still shows the reset word
  volt_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> driveStatusWord[dcsm_pkg::SW_VOLT] == $past(mainsPresent))
    else $error("voltage bit not mirroring mains");
  fault_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (stateReg == dcsm_pkg::DCSM_FAULT && !faultRstPulse) |=> stateReg != dcsm_pkg::DCSM_SODIS)
    else $error("fault left without reset edge");
  sodis_code_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stateReg == dcsm_pkg::DCSM_SODIS |-> driveStatusWord[3:0] == 4'h0 &&
    driveStatusWord[dcsm_pkg::SW_SODIS])
    else $error("switch-on disabled code wrong");
  qstop_motion_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (motionControl && srcSel && stateReg == dcsm_pkg::DCSM_QSTOP && !faultDetected)
    |=> stateReg == dcsm_pkg::DCSM_SODIS)
    else $error("quick stop behaviour applied in motion control");

endmodule // dcsm_drive_control

//--- testbench/dcsm_host_model.sv
// Host controller model: holds the command word it was last asked to send.
// Assumes the bench requests a new word through loadWord and wordIn.
`timescale 1ns/1ps
module dcsm_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        loadWord,
  input  wire logic [15:0] wordIn,
  output logic      [15:0] driveCommandWord
);
  // Word changes just after the edge, so the block never samples it mid-change
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      driveCommandWord <= 16'h0000;
    end else if (loadWord) begin
      driveCommandWord <= #1 wordIn;
    end
  end
endmodule // dcsm_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the drive-control state machine.
// Assumes the host model presents the command word one cycle after a request.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic loadWord = 1'b0;
  logic [15:0] wordIn = 16'h0000;
  logic [15:0] driveCommandWord, driveStatusWord;
  logic [5:0] controlSource = 6'h01;
  logic [1:0] transition5Mode = 2'h0, opModeStatus = 2'h0;
  logic motionControl = 0, safeReleaseA = 1, safeReleaseB = 1, digitalInputOne = 1;
  logic startClockwiseInput = 1, startAnticlockwiseInput = 0, mainsPresent = 1;
  logic faultDetected = 0, faultReactionDone = 0, stopDone = 0, holdTimeExpired = 0;
  logic brakeDone = 0, internalWarning = 0, targetInHysteresis = 0, powerFailAtZero = 0;
  logic limitActive = 0, preFaultWarning = 0;
  logic inverterEnable, rampStopActive, emergencyRampActive, dcBrakeActive;
  logic [3:0] motionCmdBits;
  int n_fail = 0;
  int total_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  dcsm_host_model i_dcsm_host_model (.clk_sys(clk_sys), .rst_b(rst_b), .loadWord(loadWord),
    .wordIn(wordIn), .driveCommandWord(driveCommandWord));

  dcsm_drive_control i_dcsm_drive_control (.clk_sys(clk_sys), .rst_b(rst_b),
    .driveCommandWord(driveCommandWord), .controlSource(controlSource),
    .motionControl(motionControl), .transition5Mode(transition5Mode),
    .safeReleaseA(safeReleaseA), .safeReleaseB(safeReleaseB),
    .digitalInputOne(digitalInputOne), .startClockwiseInput(startClockwiseInput),
    .startAnticlockwiseInput(startAnticlockwiseInput), .mainsPresent(mainsPresent),
    .faultDetected(faultDetected), .faultReactionDone(faultReactionDone),
    .stopDone(stopDone), .holdTimeExpired(holdTimeExpired), .brakeDone(brakeDone),
    .internalWarning(internalWarning), .targetInHysteresis(targetInHysteresis),
    .powerFailAtZero(powerFailAtZero), .limitActive(limitActive),
    .preFaultWarning(preFaultWarning), .opModeStatus(opModeStatus),
    .driveStatusWord(driveStatusWord), .inverterEnable(inverterEnable),
    .rampStopActive(rampStopActive), .emergencyRampActive(emergencyRampActive),
    .dcBrakeActive(dcBrakeActive), .motionCmdBits(motionCmdBits));

  // Compare and count; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ask the host for a word; status is settled when this returns
  task automatic send(input logic [15:0] w);
    wordIn = w;
    loadWord = 1'b1;
    @(posedge clk_sys) #1;
    loadWord = 1'b0;
    @(posedge clk_sys) #1;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys) #1;
  endtask

  // Bounded wait for a state code in status bits 6..0
  task automatic wait_st(input string what, input logic [6:0] exp);
    for (int i = 0; i < 20 && driveStatusWord[6:0] !== exp; i++) tick(1);
    chk(what, {9'h000, driveStatusWord[6:0]}, {9'h000, exp});
  endtask

  task automatic t_walk();
    send(16'h0006); chk("ready", driveStatusWord, 16'h0231);
    send(16'h0007); chk("switched on", driveStatusWord, 16'h0233);
    send(16'h000F); chk("enabled", driveStatusWord, 16'h0237);
    chk("inverter on", {15'h0000, inverterEnable}, 16'h0001);
  endtask

  task automatic t_qstop();
    send(16'h000B); chk("qstop", {9'h0, driveStatusWord[6:0]}, 16'h0017);
    chk("emerg ramp", {15'h0000, emergencyRampActive}, 16'h0001);
    stopDone = 1'b1;
    tick(3); chk("hold", {9'h0, driveStatusWord[6:0]}, 16'h0017);
    chk("hold dc", {15'h0000, dcBrakeActive}, 16'h0001);
    holdTimeExpired = 1'b1;
    wait_st("qstop end", 7'h50);
    stopDone = 1'b0;
    holdTimeExpired = 1'b0;
  endtask

  task automatic t_nomains();
    send(16'h0006);
    mainsPresent = 1'b0;
    send(16'h0007); chk("no mains", {9'h0, driveStatusWord[6:0]}, 16'h0021);
    mainsPresent = 1'b1;
    wait_st("mains back", 7'h33);
  endtask

  task automatic t_gate();
    startClockwiseInput = 1'b0;
    send(16'h000F); chk("no start", {9'h0, driveStatusWord[6:0]}, 16'h0033);
    motionControl = 1'b1;
    opModeStatus = 2'h3;
    wait_st("motion enable", 7'h37);
    send(16'h015F); chk("motion bits", {12'h000, motionCmdBits}, 16'h000D);
    chk("opmode bits", {14'h0, driveStatusWord[13:12]}, 16'h0003);
    send(16'h000B); chk("motion qstop", {9'h0, driveStatusWord[6:0]}, 16'h0017);
    chk("no emerg ramp", {15'h0000, emergencyRampActive}, 16'h0000);
    wait_st("motion qstop end", 7'h50);
    send(16'h0006);
    send(16'h0007); chk("motion swon", {9'h0, driveStatusWord[6:0]}, 16'h0033);
    motionControl = 1'b0;
    startClockwiseInput = 1'b1;
    send(16'hFE0F); chk("bits ignored", {12'h000, motionCmdBits}, 16'h0000);
    chk("high bits", driveStatusWord & 16'h307F, 16'h0037);
  endtask

  task automatic t_t5();
    transition5Mode = dcsm_pkg::T5_COAST;
    send(16'h0007); chk("coast", {9'h0, driveStatusWord[6:0]}, 16'h0033);
    send(16'h000F);
    transition5Mode = dcsm_pkg::T5_DCBRAKE;
    send(16'h0007); chk("dc brake", {15'h0000, dcBrakeActive}, 16'h0001);
    brakeDone = 1'b1;
    wait_st("brake end", 7'h33);
    brakeDone = 1'b0;
    send(16'h000F);
    transition5Mode = dcsm_pkg::T5_RAMP;
    send(16'h0007); chk("ramp", {14'h0, rampStopActive, driveStatusWord[2]}, 16'h0003);
    stopDone = 1'b1;
    holdTimeExpired = 1'b1;
    wait_st("ramp end", 7'h33);
    stopDone = 1'b0;
    holdTimeExpired = 1'b0;
  endtask

  task automatic t_fault();
    faultDetected = 1'b1;
    tick(1); chk("reaction", driveStatusWord & 16'h004F, 16'h000F);
    faultReactionDone = 1'b1;
    tick(2); chk("fault", driveStatusWord & 16'h004F, 16'h0008);
    faultDetected = 1'b0;
    faultReactionDone = 1'b0;
    send(16'h0000); chk("no reset", driveStatusWord & 16'h004F, 16'h0008);
    send(16'h0080); chk("reset", driveStatusWord & 16'h004F, 16'h0040);
  endtask

  task automatic t_misc();
    controlSource = 6'h02;
    send(16'h0006); chk("source", driveStatusWord & 16'h027F, 16'h0050);
    controlSource = 6'h01;
    {internalWarning, targetInHysteresis, limitActive, preFaultWarning} = 4'hF;
    tick(2); chk("flags", driveStatusWord & 16'h8C80, 16'h8C80);
    {internalWarning, targetInHysteresis, limitActive, preFaultWarning} = 4'h0;
    powerFailAtZero = 1'b1;
    tick(2); chk("zero hz", driveStatusWord & 16'h8C80, 16'h0400);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Whole sequence takes about 70 cycles; watchdog allows far more
  initial begin
    #100000;
    n_fail++;
    results();
  end

  initial begin
    tick(12); chk("reset status", driveStatusWord, 16'h0040);
    rst_b = 1'b1;
    tick(2); chk("idle", driveStatusWord, 16'h0250);
    t_walk();
    t_qstop();
    t_nomains();
    t_gate();
    t_t5();
    t_fault();
    t_misc();
    results();
  end
endmodule // tb_top
